// ---- hw/sra_pkg.sv ----
// Constants and carrier types for the serial register access port.
// Assumes a consumer that imports nothing and names every item with sra_pkg::.
package sra_pkg;
  // Header byte 0 layout: write flag, full-mode flag, base address, fast-command flag
  localparam int HDR_WRITE_BIT = 7;
  localparam int HDR_FULL_BIT  = 6;
  localparam int HDR_BASE_HI   = 5;
  localparam int HDR_BASE_LO   = 1;
  localparam int HDR_FLAG_BIT  = 0;
  // Header byte 1 layout (full mode): offset, then pad or masked-write flag
  localparam int OFS_HI        = 7;
  localparam int OFS_LO        = 1;
  localparam int OFS_MASK_BIT  = 0;
  // Mask configuration byte: operation and length code
  localparam int MCFG_OP_HI    = 7;
  localparam int MCFG_OP_LO    = 6;
  localparam int MCFG_LEN_HI   = 5;
  localparam int MCFG_LEN_LO   = 4;
  localparam logic [1:0] OP_SET    = 2'h0;
  localparam logic [1:0] OP_CLEAR  = 2'h1;
  localparam logic [1:0] OP_TOGGLE = 2'h2;
  localparam logic [1:0] LEN_1     = 2'h0;
  localparam logic [1:0] LEN_2     = 2'h1;
  localparam logic [2:0] LEFT_1    = 3'h1;
  localparam logic [2:0] LEFT_2    = 3'h2;
  localparam logic [2:0] LEFT_4    = 3'h4;
  localparam int ADDR_W   = 12;
  localparam int GPIO_N   = 8;
  localparam int SCK_MAX_MHZ = 32;
  // Clock mode register sits at base 0x1F, offset 0; bit0 polarity, bit1 phase
  localparam logic [ADDR_W-1:0] MODE_ADDR = 12'hF80;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 12'h001;
  localparam logic [6:0] OFS_ZERO = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] CNT_ONE  = 3'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic MODE_POL_RESET = 1'b0;
  localparam logic MODE_PHA_RESET = 1'b0;
  localparam logic [GPIO_N-1:0] PULL_EN_RESET = 8'hFF;
  localparam logic [GPIO_N-1:0] PULL_UP_RESET = 8'h00;
  localparam logic CS_PULL_UP_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR1, ST_MCFG, ST_MASK, ST_RD, ST_WR, ST_DONE
  } sra_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } sra_reg_req_t;

  typedef struct packed {
    logic              cs_pull_up;
    logic [GPIO_N-1:0] gpio_en;
    logic [GPIO_N-1:0] gpio_up;
  } sra_pull_t;
endpackage

// ---- hw/sra_port.sv ----
// Serial register access port: four-wire peripheral, all modes, byte-wide register port.
// Assumes reg_rdata follows reg_req.addr within the rd cycle; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sra_port (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    host_select_n,
  input  wire logic                    serial_clock,
  input  wire logic                    host_to_peripheral_line,
  output logic                         peripheral_to_host_line,
  output logic                         peripheral_to_host_line_oe,
  input  wire logic                    otp_mode_valid,
  input  wire logic [1:0]              otp_mode,
  output sra_pkg::sra_reg_req_t        reg_req,
  input  wire logic [7:0]              reg_rdata,
  output logic                         cmd_strobe,
  output logic [4:0]                   cmd_code,
  output logic                         clock_polarity_sel,
  output logic                         clock_phase_sel,
  input  wire logic                    pull_cfg_we,
  input  wire sra_pkg::sra_pull_t      pull_cfg,
  output sra_pkg::sra_pull_t           pull_state
);
  typedef struct packed {
    logic                      cs_s1;
    logic                      cs_s2;
    logic                      sck_s1;
    logic                      sck_s2;
    logic                      sck_q;
    logic                      dat_s1;
    logic                      dat_s2;
    logic                      cpol;
    logic                      cpha;
    logic                      pend;
    logic                      pend_pol;
    logic                      pend_pha;
    logic                      otp_done;
    sra_pkg::sra_state_t       st;
    logic [2:0]                cnt;
    logic [7:0]                rx;
    logic [7:0]                tx;
    logic                      miso;
    logic                      wr_cmd;
    logic [sra_pkg::ADDR_W-1:0] addr;
    logic                      fetch;
    logic                      rmw;
    logic [7:0]                mask;
    logic [1:0]                op;
    logic [2:0]                left;
    sra_pkg::sra_reg_req_t     req;
    logic                      cmd_stb;
    logic [4:0]                code;
    sra_pkg::sra_pull_t        pull;
  } sra_core_t;

  sra_core_t s;
  sra_core_t next_s;
  logic      rise;
  logic      fall;
  logic      lead;
  logic      trail;
  logic      sample;
  logic      shift;
  logic [7:0] b;
  logic      byte_done;

  always_comb begin
    next_s = s;
    // Sync stages; logic uses the second stage, plus sck_q one clk behind it for edge detect
    next_s.cs_s1 = host_select_n;
    next_s.cs_s2 = s.cs_s1;
    next_s.sck_s1 = serial_clock;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_q = s.sck_s2;
    next_s.dat_s1 = host_to_peripheral_line;
    next_s.dat_s2 = s.dat_s1;
    next_s.req.rd = 1'b0;
    next_s.req.wr = 1'b0;
    next_s.cmd_stb = 1'b0;
    next_s.fetch = 1'b0;
    rise = s.sck_s2 & ~s.sck_q;
    fall = ~s.sck_s2 & s.sck_q;
    lead = s.cpol ? fall : rise;
    trail = s.cpol ? rise : fall;
    sample = s.cpha ? trail : lead;
    shift = s.cpha ? lead : trail;
    b = {s.rx[6:0], s.dat_s2};
    byte_done = sample & ~s.cs_s2 & (s.cnt == sra_pkg::BIT_LAST);
    // Strap caught once, the first clock after reset release
    if (!s.otp_done) begin
      next_s.otp_done = 1'b1;
      if (otp_mode_valid) begin
        next_s.cpol = otp_mode[0];
        next_s.cpha = otp_mode[1];
      end
    end
    if (pull_cfg_we) begin
      next_s.pull = pull_cfg;
    end
    // Read data lands one clk after the strobe
    if (s.fetch) begin
      next_s.tx = (s.req.addr == sra_pkg::MODE_ADDR) ? {6'h00, s.cpha, s.cpol} : reg_rdata;
    end
    if (s.rmw) begin
      next_s.rmw = 1'b0;
      next_s.req.wr = 1'b1;
      case (s.op)
        sra_pkg::OP_SET:    next_s.req.wdata = reg_rdata | s.mask;
        sra_pkg::OP_CLEAR:  next_s.req.wdata = reg_rdata & ~s.mask;
        sra_pkg::OP_TOGGLE: next_s.req.wdata = reg_rdata ^ s.mask;
        default:            next_s.req.wdata = reg_rdata;
      endcase
    end
    if (s.cs_s2) begin
      // Deselected: drop everything mid-byte; mode changes only between frames
      next_s.st = sra_pkg::ST_IDLE;
      next_s.cnt = 3'h0;
      next_s.rx = sra_pkg::BYTE_ZERO;
      next_s.tx = sra_pkg::BYTE_ZERO;
      next_s.miso = 1'b0;
      next_s.fetch = 1'b0;
      if (s.pend) begin
        next_s.pend = 1'b0;
        next_s.cpol = s.pend_pol;
        next_s.cpha = s.pend_pha;
      end
    end else begin
      if (shift) begin
        next_s.miso = s.tx[sra_pkg::BIT_LAST - s.cnt];
      end
      if (sample) begin
        next_s.rx = b;
        next_s.cnt = s.cnt + sra_pkg::CNT_ONE;
      end
      if (byte_done) begin
        case (s.st)
          sra_pkg::ST_IDLE: begin
            next_s.wr_cmd = b[sra_pkg::HDR_WRITE_BIT];
            next_s.addr = {b[sra_pkg::HDR_BASE_HI:sra_pkg::HDR_BASE_LO], sra_pkg::OFS_ZERO};
            if (b[sra_pkg::HDR_FULL_BIT]) begin
              next_s.st = sra_pkg::ST_HDR1;
            end else if (b[sra_pkg::HDR_FLAG_BIT]) begin
              next_s.cmd_stb = 1'b1;
              next_s.code = b[sra_pkg::HDR_BASE_HI:sra_pkg::HDR_BASE_LO];
              next_s.st = sra_pkg::ST_DONE;
            end else if (b[sra_pkg::HDR_WRITE_BIT]) begin
              next_s.st = sra_pkg::ST_WR;
            end else begin
              next_s.st = sra_pkg::ST_RD;
              next_s.req.rd = 1'b1;
              next_s.req.addr = next_s.addr;
              next_s.fetch = 1'b1;
              next_s.addr = next_s.addr + sra_pkg::ADDR_ONE;
            end
          end
          sra_pkg::ST_HDR1: begin
            next_s.addr[6:0] = b[sra_pkg::OFS_HI:sra_pkg::OFS_LO];
            if (s.wr_cmd && b[sra_pkg::OFS_MASK_BIT]) begin
              next_s.st = sra_pkg::ST_MCFG;
            end else if (s.wr_cmd) begin
              next_s.st = sra_pkg::ST_WR;
            end else begin
              next_s.st = sra_pkg::ST_RD;
              next_s.req.rd = 1'b1;
              next_s.req.addr = {s.addr[11:7], b[sra_pkg::OFS_HI:sra_pkg::OFS_LO]};
              next_s.fetch = 1'b1;
              next_s.addr = next_s.req.addr + sra_pkg::ADDR_ONE;
            end
          end
          sra_pkg::ST_MCFG: begin
            next_s.op = b[sra_pkg::MCFG_OP_HI:sra_pkg::MCFG_OP_LO];
            case (b[sra_pkg::MCFG_LEN_HI:sra_pkg::MCFG_LEN_LO])
              sra_pkg::LEN_1: next_s.left = sra_pkg::LEFT_1;
              sra_pkg::LEN_2: next_s.left = sra_pkg::LEFT_2;
              default:        next_s.left = sra_pkg::LEFT_4;
            endcase
            next_s.st = sra_pkg::ST_MASK;
          end
          sra_pkg::ST_MASK: begin
            next_s.mask = b;
            next_s.rmw = 1'b1;
            next_s.req.rd = 1'b1;
            next_s.req.addr = s.addr;
            next_s.addr = s.addr + sra_pkg::ADDR_ONE;
            next_s.left = s.left - sra_pkg::CNT_ONE;
            if (s.left == sra_pkg::LEFT_1) begin
              next_s.st = sra_pkg::ST_DONE;
            end
          end
          sra_pkg::ST_WR: begin
            // Mode writes are held until the frame ends
            if (s.addr == sra_pkg::MODE_ADDR) begin
              next_s.pend = 1'b1;
              next_s.pend_pol = b[0];
              next_s.pend_pha = b[1];
            end else begin
              next_s.req.wr = 1'b1;
            end
            next_s.req.addr = s.addr;
            next_s.req.wdata = b;
            next_s.addr = s.addr + sra_pkg::ADDR_ONE;
          end
          sra_pkg::ST_RD: begin
            next_s.req.rd = 1'b1;
            next_s.req.addr = s.addr;
            next_s.fetch = 1'b1;
            next_s.addr = s.addr + sra_pkg::ADDR_ONE;
          end
          sra_pkg::ST_DONE: next_s.st = sra_pkg::ST_DONE;
          default: next_s.st = sra_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
      s.cpol <= sra_pkg::MODE_POL_RESET;
      s.cpha <= sra_pkg::MODE_PHA_RESET;
      s.st <= sra_pkg::ST_IDLE;
      s.pull.cs_pull_up <= sra_pkg::CS_PULL_UP_RESET;
      s.pull.gpio_en <= sra_pkg::PULL_EN_RESET;
      s.pull.gpio_up <= sra_pkg::PULL_UP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign peripheral_to_host_line = s.miso;
  assign peripheral_to_host_line_oe = ~s.cs_s2;
  assign reg_req = s.req;
  assign cmd_strobe = s.cmd_stb;
  assign cmd_code = s.code;
  assign clock_polarity_sel = s.cpol;
  assign clock_phase_sel = s.cpha;
  assign pull_state = s.pull;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_tristate_desel: assert property ($past(host_select_n, 2) |-> !peripheral_to_host_line_oe)
    else $error("output enabled while deselected");
  a_abort_on_desel: assert property ($rose(s.cs_s2) |=> s.st == sra_pkg::ST_IDLE && s.cnt == 3'h0)
    else $error("state not cleared at deselect");
  a_fresh_start: assert property ($fell(s.cs_s2) |-> s.st == sra_pkg::ST_IDLE && s.cnt == 3'h0)
    else $error("frame did not start clean");
  a_msb_shift: assert property (sample && !s.cs_s2 |=> s.rx[0] == $past(s.dat_s2))
    else $error("bit not shifted in at lsb end");
  a_no_passthru: assert property (s.cs_s2 |=> !peripheral_to_host_line)
    else $error("data driven while deselected");
  a_addr_step: assert property (s.req.rd |-> s.addr == s.req.addr + sra_pkg::ADDR_ONE)
    else $error("address did not advance");
  a_read_fetch: assert property (s.req.rd && !s.rmw |-> s.fetch)
    else $error("read issued without fetch");
  a_rmw_write: assert property (s.req.rd && s.rmw |=> s.req.wr && $stable(s.req.addr))
    else $error("masked write not written back");
  a_mode_stable: assert property (!s.cs_s2 && s.otp_done |=> $stable(s.cpol) && $stable(s.cpha))
    else $error("mode changed inside frame");
  a_cmd_pulse: assert property (cmd_strobe |=> !cmd_strobe ##1 !cmd_strobe)
    else $error("command strobe longer than one cycle");
endmodule
`default_nettype wire

// ---- tb/sra_host_model.sv ----
// Host controller model driving the four-wire link from its own timing.
// Assumes the bench fills tx_buf and picks cpol/cpha only between frames.
`timescale 1ns/1ps
`default_nettype none
module sra_host_model (
  output logic      host_select_n,
  output logic      serial_clock,
  output logic      host_to_peripheral_line,
  input  wire logic peripheral_to_host_line
);
  localparam time HALF = 80ns;
  logic [7:0] tx_buf [16];
  logic [7:0] rx_buf [16];
  logic       cpol;
  logic       cpha;
  initial begin
    host_select_n = 1'b1;
    serial_clock = 1'b0;
    host_to_peripheral_line = 1'b0;
    cpol = 1'b0;
    cpha = 1'b0;
  end
  // Whole bytes first, then nbits of a cut-off byte
  task automatic frame(input int nbytes, input int nbits);
    int   k;
    logic b;
    serial_clock = cpol;
    #HALF;
    host_select_n = 1'b0;
    #HALF;
    for (k = 0; k < nbytes * 8 + nbits; k++) begin
      b = tx_buf[k / 8][7 - k % 8];
      if (!cpha) host_to_peripheral_line = b;
      #HALF;
      serial_clock = ~cpol;
      if (cpha) host_to_peripheral_line = b;
      else rx_buf[k / 8][7 - k % 8] = peripheral_to_host_line;
      #HALF;
      serial_clock = cpol;
      if (cpha) rx_buf[k / 8][7 - k % 8] = peripheral_to_host_line;
    end
    #HALF;
    host_select_n = 1'b1;
    // Released data line must not look held
    host_to_peripheral_line = ~host_to_peripheral_line;
    #HALF;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_sra_port.sv ----
// Self-checking bench for the serial register access port.
// Assumes the package, the port and the host model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_sra_port;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  otp_mode_valid = 1'b0;
  logic [1:0]            otp_mode = 2'h0;
  logic                  pull_cfg_we = 1'b0;
  sra_pkg::sra_pull_t    pull_cfg = '0;
  sra_pkg::sra_pull_t    pull_state;
  sra_pkg::sra_reg_req_t reg_req;
  logic [7:0]            reg_rdata;
  logic                  dout, dout_oe, cmd_strobe, pol, pha;
  logic [4:0]            cmd_code;
  wire                   sel_n, sck, din, line;
  logic [7:0]            mem [4096];
  logic [7:0]            v;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    n_strobe = 0;
  int                    n_wr = 0;
  int                    nq = 0;
  int                    i, k, m, w0;
  assign line = dout_oe ? dout : 1'bz;
  always #5 clk = ~clk;
  sra_host_model host_u (.host_select_n(sel_n), .serial_clock(sck),
    .host_to_peripheral_line(din), .peripheral_to_host_line(line));
  sra_port dut_u (.clk(clk), .reset_n(reset_n), .host_select_n(sel_n), .serial_clock(sck),
    .host_to_peripheral_line(din), .peripheral_to_host_line(dout),
    .peripheral_to_host_line_oe(dout_oe), .otp_mode_valid(otp_mode_valid),
    .otp_mode(otp_mode), .reg_req(reg_req), .reg_rdata(reg_rdata), .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code), .clock_polarity_sel(pol), .clock_phase_sel(pha),
    .pull_cfg_we(pull_cfg_we), .pull_cfg(pull_cfg), .pull_state(pull_state));
  // Byte register file; read follows the address, the port latches it at the next edge
  assign reg_rdata = mem[reg_req.addr];
  always @(posedge clk) begin
    if (reg_req.wr) mem[reg_req.addr] <= reg_req.wdata;
    if (reg_req.wr) n_wr <= n_wr + 1;
    if (cmd_strobe) n_strobe <= n_strobe + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [7:0] b);
    host_u.tx_buf[nq] = b;
    nq++;
  endtask
  // Frames start on a falling clk edge, away from the sampling edge
  task automatic go(input int nbits);
    @(negedge clk);
    host_u.frame(nbits > 0 ? nq - 1 : nq, nbits);
    nq = 0;
    tick(6);
  endtask
  function automatic logic [7:0] hdr(input logic w, input logic f, input logic [4:0] b,
                                     input logic x);
    return {w, f, b, x};
  endfunction
  task automatic results;
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    for (i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    check(pull_state, {1'b1, 8'hFF, 8'h00});
    check({pol, pha, dout_oe, dout}, 4'h0);
    // Trailing byte after a command must be dropped
    for (i = 1; i < 32; i += 10) begin
      w0 = n_wr;
      m = n_strobe;
      put(hdr(1'b0, 1'b0, i[4:0], 1'b1));
      put(8'hA5);
      go(0);
      check(cmd_code, i[4:0]);
      check(n_strobe, m + 1);
      check(n_wr, w0);
    end
    for (m = 0; m < 4; m++) begin
      put(hdr(1'b1, 1'b0, 5'(m + 3), 1'b0));
      for (k = 0; k < 3; k++) put(8'(8'hC0 + 16 * m + k));
      go(0);
      for (k = 0; k < 3; k++) check(mem[(m + 3) * 128 + k], 8'(8'hC0 + 16 * m + k));
      put(hdr(1'b0, 1'b0, 5'(m + 3), 1'b0));
      for (k = 0; k < 3; k++) put(8'hFF);
      go(0);
      for (k = 0; k < 3; k++) check(host_u.rx_buf[k + 1], 8'(8'hC0 + 16 * m + k));
      v = 8'((m + 1) % 4);
      put(hdr(1'b1, 1'b0, 5'h1F, 1'b0));
      put(v);
      go(0);
      check({pha, pol}, v[1:0]);
      host_u.cpol = v[0];
      host_u.cpha = v[1];
      put(hdr(1'b0, 1'b0, 5'h1F, 1'b0));
      put(8'hFF);
      go(0);
      check(host_u.rx_buf[1], v);
    end
    // Offset near the top so the burst carries into the base
    put(hdr(1'b1, 1'b1, 5'h02, 1'b0));
    put({7'h7E, 1'b0});
    for (k = 0; k < 3; k++) put(8'(8'h70 + k));
    go(0);
    for (k = 0; k < 3; k++) check(mem[12'h17E + k], 8'(8'h70 + k));
    put(hdr(1'b0, 1'b1, 5'h02, 1'b0));
    put({7'h7E, 1'b0});
    for (k = 0; k < 3; k++) put(8'hFF);
    go(0);
    for (k = 0; k < 3; k++) check(host_u.rx_buf[k + 2], 8'(8'h70 + k));
    // One spare mask byte beyond the length must not land
    for (i = 0; i < 9; i++) begin
      for (k = 0; k < 5; k++) mem[12'h210 + k] = 8'h5A;
      put(hdr(1'b1, 1'b1, 5'h04, 1'b0));
      put({7'h10, 1'b1});
      put({2'(i / 3), 2'(i % 3), 4'h0});
      for (k = 0; k <= (1 << (i % 3)); k++) put(8'(8'h3C + k));
      go(0);
      for (k = 0; k <= (1 << (i % 3)); k++) begin
        v = 8'(8'h3C + k);
        v = (k == (1 << (i % 3))) ? 8'h5A : (i < 3) ? (8'h5A | v) :
            (i < 6) ? (8'h5A & ~v) : (8'h5A ^ v);
        check(mem[12'h210 + k], v);
      end
    end
    mem[12'h301] = 8'hEE;
    put(hdr(1'b1, 1'b0, 5'h06, 1'b0));
    put(8'h11);
    put(8'h22);
    go(4);
    check({mem[12'h300], mem[12'h301]}, 16'h11EE);
    put(hdr(1'b0, 1'b0, 5'h06, 1'b0));
    put(8'hFF);
    put(8'hFF);
    go(0);
    check({host_u.rx_buf[1], host_u.rx_buf[2]}, 16'h11EE);
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      host_u.host_to_peripheral_line = k[0];
      tick(4);
      check({dout_oe, dout}, 2'h0);
    end
    @(posedge clk);
    pull_cfg <= {1'b0, 8'h0F, 8'hA5};
    pull_cfg_we <= 1'b1;
    @(posedge clk);
    pull_cfg_we <= 1'b0;
    #1;
    check(pull_state, {1'b0, 8'h0F, 8'hA5});
    @(posedge clk);
    reset_n <= 1'b0;
    otp_mode_valid <= 1'b1;
    otp_mode <= 2'h3;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    check({pha, pol, pull_state}, {2'h3, 1'b1, 8'hFF, 8'h00});
    results();
  end
endmodule
`default_nettype wire
